/* rtl/psf_pkg.sv */
// Package of constants and carriers for the program status flag logic.
package psf_pkg;
    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam logic [1:0] PSW_ADDR       = 2'h0;
    localparam logic [1:0] ACC_ADDR       = 2'h1;
    localparam logic [1:0] BANK_ADDR      = 2'h2;
    localparam logic [7:0] PSW_RESET      = 8'h00;
    localparam logic [7:0] ACC_RESET      = 8'h00;
    // ---------------------------------------------------------------
    // Status word field positions
    // ---------------------------------------------------------------
    localparam int CARRY_BIT   = 7;
    localparam int HALF_BIT    = 6;
    localparam int USER_A_BIT  = 5;
    localparam int BANK_HI_BIT = 4;
    localparam int BANK_LO_BIT = 3;
    localparam int RANGE_BIT   = 2;
    localparam int USER_B_BIT  = 1;
    localparam int PARITY_BIT  = 0;
    localparam logic [7:0] MUL_LIMIT = 8'hFF;
    localparam logic [4:0] BANK_SIZE = 5'h08;

    typedef enum logic [3:0] {
        PSF_OP_NONE = 4'h0,
        PSF_OP_ADD  = 4'h1,
        PSF_OP_ADDC = 4'h2,
        PSF_OP_SUBB = 4'h3,
        PSF_OP_MUL  = 4'h4,
        PSF_OP_DIV  = 4'h5
    } psf_op_e;

    typedef struct packed {
        psf_op_e    op;
        logic [7:0] a;
        logic [7:0] b;
    } psf_alu_req_s;

    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       half;
        logic       range;
    } psf_alu_res_s;
endpackage

/* rtl/psf_alu.sv */
// Combinational arithmetic unit that yields result and flags.
`timescale 1ns/100ps
`default_nettype none
module psf_alu (
    // Request
    input  wire psf_pkg::psf_alu_req_s req,
    input  wire logic                  carry_in,
    // Answer
    output var psf_pkg::psf_alu_res_s  res
);
    logic [8:0]  sum9;
    logic [7:0]  sum7;
    logic [4:0]  sum4;
    logic [15:0] prod;
    logic        cin;
    always_comb begin
        res  = '0;
        cin  = (req.op == psf_pkg::PSF_OP_ADD) ? 1'b0 : carry_in;
        sum9 = '0;
        sum7 = '0;
        sum4 = '0;
        prod = req.a * req.b;
        case (req.op)
            psf_pkg::PSF_OP_ADD, psf_pkg::PSF_OP_ADDC: begin
                sum9 = {1'b0, req.a} + {1'b0, req.b} + {8'h00, cin};
                sum7 = {1'b0, req.a[6:0]} + {1'b0, req.b[6:0]} + {7'h00, cin};
                sum4 = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, cin};
                res.result = sum9[7:0];
                res.carry  = sum9[8];
                res.half   = sum4[4];
                res.range  = sum9[8] ^ sum7[7];
            end
            psf_pkg::PSF_OP_SUBB: begin
                // Borrows are bit 8 of a - b - c, stored in the carry flag without inversion.
                sum9 = {1'b0, req.a} - {1'b0, req.b} - {8'h00, carry_in};
                sum7 = {1'b0, req.a[6:0]} - {1'b0, req.b[6:0]} - {7'h00, carry_in};
                sum4 = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, carry_in};
                res.result = sum9[7:0];
                res.carry  = sum9[8];
                res.half   = sum4[4];
                res.range  = sum9[8] ^ sum7[7];
            end
            psf_pkg::PSF_OP_MUL: begin
                res.result = prod[7:0];
                res.range  = prod[15:8] != 8'h00;
            end
            psf_pkg::PSF_OP_DIV: begin
                // Quotient is undefined on a zero divisor; zero is returned.
                res.result = (req.b == 8'h00) ? 8'h00 : req.a / req.b;
                res.range  = req.b == 8'h00;
            end
            default: begin
                res = '0;
            end
        endcase
    end
endmodule
`default_nettype wire

/* rtl/psf_flags.sv */
// Program status word flag logic with its accumulator and bank mapping.
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module psf_flags (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // Register port
    input  wire logic [1:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [7:0]                 reg_rdata,
    // Execution
    input  wire psf_pkg::psf_alu_req_s exec_req,
    input  wire logic                  exec_valid,
    // Status
    output logic [7:0]                 program_status_word,
    output logic [7:0]                 acc_value,
    output logic [4:0]                 bank_base
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [7:0]            psw_q, psw_d;
    logic [7:0]            acc_q, acc_d;
    logic [7:0]            rdata_q, rdata_d;
    psf_pkg::psf_alu_res_s alu_res;
    logic                  parity;

    psf_alu u_alu (
        .req      (exec_req),
        .carry_in (psw_q[psf_pkg::CARRY_BIT]),
        .res      (alu_res)
    );

    // Parity is taken from the stored accumulator, so it can never disagree with it.
    function automatic logic parity_of(input logic [7:0] value);
        parity_of = ^value;
    endfunction

    assign parity = parity_of(acc_q);

    function automatic logic [4:0] bank_of(input logic [1:0] sel);
        bank_of = 5'(sel * psf_pkg::BANK_SIZE);
    endfunction

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        psw_d   = psw_q;
        acc_d   = acc_q;
        rdata_d = 8'h00;
        // Execution updates only arithmetic flags; user and bank bits stay put.
        if (exec_valid && exec_req.op != psf_pkg::PSF_OP_NONE) begin
            acc_d = alu_res.result;
            psw_d[psf_pkg::CARRY_BIT] = alu_res.carry;
            psw_d[psf_pkg::RANGE_BIT] = alu_res.range;
            if (exec_req.op != psf_pkg::PSF_OP_MUL && exec_req.op != psf_pkg::PSF_OP_DIV) begin
                psw_d[psf_pkg::HALF_BIT] = alu_res.half;
            end
        end
        // A software write in the same cycle wins, as the later store.
        if (reg_wr) begin
            case (reg_addr)
                psf_pkg::PSW_ADDR: psw_d = reg_wdata;
                psf_pkg::ACC_ADDR: acc_d = reg_wdata;
                default: ;
            endcase
        end
        psw_d[psf_pkg::PARITY_BIT] = 1'b0;
        if (reg_rd) begin
            case (reg_addr)
                psf_pkg::PSW_ADDR:  rdata_d = {psw_q[7:1], parity};
                psf_pkg::ACC_ADDR:  rdata_d = acc_q;
                psf_pkg::BANK_ADDR: rdata_d = {3'h0, bank_of(psw_q[4:3])};
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            psw_q   <= psf_pkg::PSW_RESET;
            acc_q   <= psf_pkg::ACC_RESET;
            rdata_q <= 8'h00;
        end else begin
            psw_q   <= psw_d;
            acc_q   <= acc_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata           = rdata_q;
    assign program_status_word = {psw_q[7:1], parity};
    assign acc_value           = acc_q;
    assign bank_base           = bank_of(psw_q[4:3]);

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    user_flag_keep_a: assert property (@(posedge mclk) disable iff (srst)
        !$past(reg_wr) |-> psw_q[5] == $past(psw_q[5]))
        else $error("user flag a changed without a write");
    user_flag_b_a: assert property (@(posedge mclk) disable iff (srst)
        !$past(reg_wr) |-> psw_q[1] == $past(psw_q[1]))
        else $error("user flag b changed without a write");
    bank_map_a: assert property (@(posedge mclk) disable iff (srst)
        bank_base == {psw_q[4:3], 3'b000})
        else $error("bank base wrong");
    add_range_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_ADD |=>
        psw_q[2] == (($past(exec_req.a[7]) == $past(exec_req.b[7]))
                     && (acc_q[7] != $past(exec_req.a[7]))))
        else $error("add overflow wrong");
    mul_range_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_MUL |=>
        psw_q[2] == (($past(exec_req.a) * $past(exec_req.b)) > 16'(psf_pkg::MUL_LIMIT))
        && !psw_q[7])
        else $error("multiply flags wrong");
    div_zero_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_DIV |=>
        psw_q[2] == ($past(exec_req.b) == 8'h00) && !psw_q[7])
        else $error("divide flags wrong");
    sub_carry_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_SUBB |=>
        psw_q[7] == ({1'b0, $past(exec_req.a)} < ({1'b0, $past(exec_req.b)}
                     + {8'h00, $past(psw_q[7])})))
        else $error("borrow wrong");
    parity_even_a: assert property (@(posedge mclk) disable iff (srst)
        ^{acc_value, program_status_word[0]} == 1'b0)
        else $error("parity not even");

    // ---------------------------------------------------------------
    // Execution checks
    // ---------------------------------------------------------------
    // A software write in the same cycle overrides execution, so these skip it.

    addc_range_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_ADDC |=>
        psw_q[2] == (($past(exec_req.a[7]) == $past(exec_req.b[7]))
                     && (acc_q[7] != $past(exec_req.a[7]))))
        else $error("add with carry overflow wrong");

    subb_range_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_SUBB |=>
        psw_q[2] == (($past(exec_req.a[7]) != $past(exec_req.b[7]))
                     && (acc_q[7] != $past(exec_req.a[7]))))
        else $error("subtract overflow wrong");

    add_carry_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_ADD |=>
        psw_q[7] == (({1'b0, $past(exec_req.a)} + {1'b0, $past(exec_req.b)}) > 9'h0FF))
        else $error("add carry wrong");

    add_half_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_ADD |=>
        psw_q[6] == (({1'b0, $past(exec_req.a[3:0])} + {1'b0, $past(exec_req.b[3:0])})
                     > 5'h0F))
        else $error("add half carry wrong");

    subb_half_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_SUBB |=>
        psw_q[6] == ({1'b0, $past(exec_req.a[3:0])} < ({1'b0, $past(exec_req.b[3:0])}
                     + {4'h0, $past(psw_q[7])})))
        else $error("subtract half borrow wrong");

    // Multiply and divide leave the half carry alone; a user must not rely on it there.
    muldiv_half_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr
        && (exec_req.op == psf_pkg::PSF_OP_MUL || exec_req.op == psf_pkg::PSF_OP_DIV) |=>
        psw_q[6] == $past(psw_q[6]))
        else $error("half carry changed by multiply or divide");

    mul_result_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_MUL |=>
        acc_q == 8'($past(exec_req.a) * $past(exec_req.b)))
        else $error("multiply low byte wrong");

    div_result_a: assert property (@(posedge mclk) disable iff (srst)
        exec_valid && !reg_wr && exec_req.op == psf_pkg::PSF_OP_DIV
        && exec_req.b != 8'h00 |=>
        acc_q == $past(exec_req.a) / $past(exec_req.b))
        else $error("divide quotient wrong");

    // ---------------------------------------------------------------
    // Register port checks
    // ---------------------------------------------------------------

    parity_store_a: assert property (@(posedge mclk) disable iff (srst)
        psw_q[psf_pkg::PARITY_BIT] == 1'b0)
        else $error("parity bit stored");

    psw_write_a: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == psf_pkg::PSW_ADDR |=>
        psw_q[7:1] == $past(reg_wdata[7:1]))
        else $error("status word write lost");

    acc_write_a: assert property (@(posedge mclk) disable iff (srst)
        reg_wr && reg_addr == psf_pkg::ACC_ADDR |=>
        acc_q == $past(reg_wdata))
        else $error("accumulator write lost");

    rdata_idle_a: assert property (@(posedge mclk) disable iff (srst)
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data without a read");
endmodule
`default_nettype wire

/* verification/psf_flags_tb.sv */
// Self-checking testbench for the program status flag logic.
`timescale 1ns/100ps
`default_nettype none
module psf_flags_tb;
    logic                  mclk;
    logic                  srst;
    logic [1:0]            reg_addr;
    logic [7:0]            reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [7:0]            reg_rdata;
    psf_pkg::psf_alu_req_s exec_req;
    logic                  exec_valid;
    logic [7:0]            program_status_word;
    logic [7:0]            acc_value;
    logic [4:0]            bank_base;
    logic [7:0]            e_psw;
    logic [7:0]            e_acc;
    int                    n_errors;
    int                    compares;

    psf_flags u_dut (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .exec_req(exec_req),
        .exec_valid(exec_valid), .program_status_word(program_status_word),
        .acc_value(acc_value), .bank_base(bank_base));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ---------------------------------------------------------------
    // Access tasks
    // ---------------------------------------------------------------
    task automatic check8(input string nm, input logic [7:0] ex, input logic [7:0] got);
        compares++;
        if (got !== ex) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Parity is never taken from the written byte, only from the accumulator.
    task automatic chk();
        check8("psw", {e_psw[7:1], ^e_acc}, program_status_word);
        check8("acc", e_acc, acc_value);
        check8("bank", {3'h0, e_psw[4:3], 3'h0}, {3'h0, bank_base});
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        if (a == psf_pkg::PSW_ADDR) e_psw = d;
        if (a == psf_pkg::ACC_ADDR) e_acc = d;
        #1;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] ex, input string nm);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check8(nm, ex, reg_rdata);
    endtask

    task automatic run(input psf_pkg::psf_op_e op, input logic [7:0] a, input logic [7:0] b);
        logic        c;
        logic        c6;
        logic [8:0]  s;
        logic [15:0] p;
        c = (op == psf_pkg::PSF_OP_ADD) ? 1'b0 : e_psw[7];
        if (op == psf_pkg::PSF_OP_SUBB) begin
            s = {1'b0, a} - {1'b0, b} - c;
            c6 = {1'b0, a[6:0]} < {1'b0, b[6:0]} + c;
            e_psw[6] = {1'b0, a[3:0]} < {1'b0, b[3:0]} + c;
        end else if (op != psf_pkg::PSF_OP_MUL && op != psf_pkg::PSF_OP_DIV) begin
            s = {1'b0, a} + b + c;
            c6 = {1'b0, a[6:0]} + b[6:0] + c > 8'h7F;
            e_psw[6] = {1'b0, a[3:0]} + b[3:0] + c > 5'h0F;
        end else begin
            s = '0;
            c6 = 1'b0;
        end
        p = a * b;
        if (op == psf_pkg::PSF_OP_MUL) begin
            e_psw[7] = 1'b0;
            e_psw[2] = p > 16'h00FF;
            e_acc = p[7:0];
        end else if (op == psf_pkg::PSF_OP_DIV) begin
            e_psw[7] = 1'b0;
            e_psw[2] = b == 8'h00;
            e_acc = (b == 8'h00) ? 8'h00 : a / b;
        end else begin
            e_psw[7] = s[8];
            e_psw[2] = c6 ^ s[8];
            e_acc = s[7:0];
        end
        @(posedge mclk);
        exec_req   <= '{op: op, a: a, b: b};
        exec_valid <= 1'b1;
        @(posedge mclk);
        exec_valid <= 1'b0;
        #1;
        chk();
    endtask

    // ---------------------------------------------------------------
    // Test sequence
    // ---------------------------------------------------------------
    initial begin
        srst = 1'b1; reg_addr = 2'h0; reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0;
        exec_req = '0; exec_valid = 1'b0; n_errors = 0; compares = 0;
        e_psw = psf_pkg::PSW_RESET; e_acc = psf_pkg::ACC_RESET;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk();
        for (int i = 0; i < 4; i++) begin
            wr(psf_pkg::PSW_ADDR, 8'hE7 | 8'(i * 8));
            chk();
            rd(psf_pkg::BANK_ADDR, 8'(i * 8), "bank_rd");
        end
        for (int i = 0; i < 7; i++) begin
            wr(psf_pkg::ACC_ADDR, 8'(i * 37));
            chk();
        end
        wr(psf_pkg::BANK_ADDR, 8'hFF);
        chk();
        rd(2'h3, 8'h00, "unmapped");
        wr(psf_pkg::PSW_ADDR, 8'h33);
        rd(psf_pkg::PSW_ADDR, {e_psw[7:1], ^e_acc}, "psw_rd");
        run(psf_pkg::PSF_OP_ADD, 8'h7F, 8'h01);
        run(psf_pkg::PSF_OP_ADD, 8'h80, 8'h80);
        run(psf_pkg::PSF_OP_ADD, 8'hFF, 8'h01);
        run(psf_pkg::PSF_OP_ADDC, 8'h7F, 8'h00);
        run(psf_pkg::PSF_OP_SUBB, 8'h80, 8'h01);
        run(psf_pkg::PSF_OP_SUBB, 8'h00, 8'h01);
        run(psf_pkg::PSF_OP_SUBB, 8'h7F, 8'hFF);
        run(psf_pkg::PSF_OP_MUL, 8'h10, 8'h10);
        run(psf_pkg::PSF_OP_MUL, 8'h0F, 8'h11);
        run(psf_pkg::PSF_OP_DIV, 8'h64, 8'h07);
        run(psf_pkg::PSF_OP_DIV, 8'h64, 8'h00);
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        e_psw = psf_pkg::PSW_RESET;
        e_acc = psf_pkg::ACC_RESET;
        #1;
        chk();
        print_verdict();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        #20000;
        n_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
